// ---- hdl/astg_gate.sv ----
// module: acquisition start trigger gate with AXI4-Lite registers
`timescale 1ns/100ps
module astg_gate
  import astg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_start_edge_signal,
  input wire logic frame_start_trig,
  output logic frame_start_accept,
  output logic acq_start_pulse,
  output logic waiting_frame_start
);
  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // ----------------------------------------------------------------
  // configuration and trigger state
  // ----------------------------------------------------------------
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [7:0] fcnt_r, fcnt_nxt;
  logic active_r, active_nxt;
  logic sw_trig_r, sw_trig_nxt;
  astg_state_e state_r, state_nxt;
  logic [7:0] count_r, count_nxt;
  logic ext_meta_r, ext_sync_r, ext_prev_r;
  logic start_pulse_r, start_pulse_nxt;
  logic accept_r, accept_nxt;

  logic do_write;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic ext_edge;
  logic start_trig;

  function automatic logic ofs_mapped(input logic [7:0] ofs);
    ofs_mapped = (ofs == ASTG_CTRL_OFS) || (ofs == ASTG_FCNT_OFS) ||
                 (ofs == ASTG_CMD_OFS) || (ofs == ASTG_STAT_OFS);
  endfunction : ofs_mapped

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_ofs = 8'(awaddr_r) & 8'hfc;
  assign rd_ofs = 8'(s_axi_araddr) & 8'hfc;
  assign do_write = aw_got_r && w_got_r && !bvalid_r;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = ofs_mapped(wr_ofs) ? ASTG_RESP_OKAY : ASTG_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = ofs_mapped(rd_ofs) ? ASTG_RESP_OKAY : ASTG_RESP_SLVERR;
      case (rd_ofs)
        ASTG_CTRL_OFS: rdata_nxt = {27'h0, ctrl_r};
        ASTG_FCNT_OFS: rdata_nxt = {24'h0, fcnt_r};
        ASTG_STAT_OFS: rdata_nxt = {16'h0, count_r, 6'h0, active_r, state_r == ASTG_WAIT_FRAME};
        default: rdata_nxt = 32'h0;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers and commands
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    fcnt_nxt = fcnt_r;
    active_nxt = active_r;
    sw_trig_nxt = 1'b0;
    if (do_write && wstrb_r[0]) begin
      case (wr_ofs)
        ASTG_CTRL_OFS: ctrl_nxt = wdata_r[4:0];
        // zero is out of range, so it is held at the floor
        ASTG_FCNT_OFS: fcnt_nxt = (wdata_r[7:0] < ASTG_FCNT_MIN) ? ASTG_FCNT_MIN : wdata_r[7:0];
        ASTG_CMD_OFS: begin
          // software trigger counts only while the target is acquisition start
          sw_trig_nxt = wdata_r[ASTG_CMD_SWTRIG_BIT] && ctrl_r[ASTG_CTRL_TGT_BIT];
          if (wdata_r[ASTG_CMD_ACQSTOP_BIT]) begin
            active_nxt = 1'b0;
          end else if (wdata_r[ASTG_CMD_ACQSTART_BIT]) begin
            active_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // external line and trigger selection
  // ----------------------------------------------------------------
  assign ext_edge = ctrl_r[ASTG_CTRL_FALL_BIT] ? (ext_prev_r && !ext_sync_r)
                                               : (!ext_prev_r && ext_sync_r);
  assign start_trig = ctrl_r[ASTG_CTRL_SRC_BIT] ? ext_edge : sw_trig_r;

  // ----------------------------------------------------------------
  // acquisition status machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    start_pulse_nxt = 1'b0;
    accept_nxt = 1'b0;
    case (state_r)
      ASTG_IDLE: begin
        count_nxt = 8'h0;
        if (active_r) begin
          // mode off: the start is made internally, no trigger needed
          start_pulse_nxt = !ctrl_r[ASTG_CTRL_MODE_BIT];
          state_nxt = ctrl_r[ASTG_CTRL_MODE_BIT] ? ASTG_WAIT_START : ASTG_WAIT_FRAME;
        end
      end
      ASTG_WAIT_START: begin
        // frame triggers are dropped here
        count_nxt = 8'h0;
        if (!ctrl_r[ASTG_CTRL_MODE_BIT]) begin
          start_pulse_nxt = 1'b1;
          state_nxt = ASTG_WAIT_FRAME;
        end else if (start_trig) begin
          start_pulse_nxt = 1'b1;
          state_nxt = ASTG_WAIT_FRAME;
        end
      end
      ASTG_WAIT_FRAME: begin
        if (frame_start_trig) begin
          accept_nxt = 1'b1;
          // with mode off the count never ends the session
          if (ctrl_r[ASTG_CTRL_MODE_BIT]) begin
            if (count_r + 8'h1 >= fcnt_r) begin
              count_nxt = 8'h0;
              state_nxt = ASTG_WAIT_START;
            end else begin
              count_nxt = count_r + 8'h1;
            end
          end
        end else if (ctrl_r[ASTG_CTRL_MODE_BIT] && !active_r) begin
          state_nxt = ASTG_WAIT_START;
        end
      end
      default: state_nxt = ASTG_IDLE;
    endcase
    if (!active_r) begin
      state_nxt = ASTG_IDLE;
      accept_nxt = 1'b0;
      start_pulse_nxt = 1'b0;
    end
  end

  assign frame_start_accept = accept_r;
  assign acq_start_pulse = start_pulse_r;
  assign waiting_frame_start = (state_r == ASTG_WAIT_FRAME);

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= ASTG_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= ASTG_RESP_OKAY;
      rdata_r <= 32'h0;
      ctrl_r <= ASTG_CTRL_RST;
      fcnt_r <= ASTG_FCNT_RST;
      active_r <= 1'b0;
      sw_trig_r <= 1'b0;
      state_r <= ASTG_IDLE;
      count_r <= 8'h0;
      start_pulse_r <= 1'b0;
      accept_r <= 1'b0;
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      fcnt_r <= fcnt_nxt;
      active_r <= active_nxt;
      sw_trig_r <= sw_trig_nxt;
      state_r <= state_nxt;
      count_r <= count_nxt;
      start_pulse_r <= start_pulse_nxt;
      accept_r <= accept_nxt;
      ext_meta_r <= external_start_edge_signal;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end
endmodule : astg_gate

// ---- include/astg_pkg.sv ----
// package: register map, field layout and reset values of the acquisition start trigger gate
package astg_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ASTG_CTRL_OFS = 8'h00;
  localparam logic [7:0] ASTG_FCNT_OFS = 8'h04;
  localparam logic [7:0] ASTG_CMD_OFS = 8'h08;
  localparam logic [7:0] ASTG_STAT_OFS = 8'h0c;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int ASTG_CTRL_MODE_BIT = 0;
  localparam int ASTG_CTRL_SRC_BIT = 1;
  localparam int ASTG_CTRL_FALL_BIT = 2;
  localparam int ASTG_CTRL_TGT_BIT = 3;
  localparam int ASTG_CTRL_CONT_BIT = 4;
  // ----------------------------------------------------------------
  // command fields (write one to execute)
  // ----------------------------------------------------------------
  localparam int ASTG_CMD_SWTRIG_BIT = 0;
  localparam int ASTG_CMD_ACQSTART_BIT = 1;
  localparam int ASTG_CMD_ACQSTOP_BIT = 2;
  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ASTG_STAT_WFS_BIT = 0;
  localparam int ASTG_STAT_ACT_BIT = 1;
  localparam int ASTG_STAT_CNT_LSB = 8;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [4:0] ASTG_CTRL_RST = 5'h00;
  localparam logic [7:0] ASTG_FCNT_RST = 8'h01;
  localparam logic [7:0] ASTG_FCNT_MIN = 8'h01;
  localparam logic [1:0] ASTG_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASTG_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ASTG_IDLE, ASTG_WAIT_START, ASTG_WAIT_FRAME} astg_state_e;
endpackage : astg_pkg

// ---- tb/astg_gate_properties.sv ----
// checker: timing relations seen at the gate's ports
`timescale 1ns/100ps
module astg_gate_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic frame_start_trig,
  input wire logic frame_start_accept,
  input wire logic acq_start_pulse,
  input wire logic waiting_frame_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  accept_needs_wait_a: assert property (frame_start_accept |-> $past(waiting_frame_start && frame_start_trig))
    else $error("frame accepted outside frame wait");
  frame_taken_a: assert property (waiting_frame_start && frame_start_trig |=> frame_start_accept)
    else $error("frame trigger not accepted");
  start_lands_wait_a: assert property (acq_start_pulse |-> waiting_frame_start)
    else $error("start pulse without frame wait");
  wait_from_start_a: assert property ($rose(waiting_frame_start) |-> acq_start_pulse)
    else $error("frame wait entered without start");
  start_one_cycle_a: assert property (acq_start_pulse |=> !acq_start_pulse)
    else $error("start pulse longer than one cycle");
  wait_end_cause_a: assert property ($fell(waiting_frame_start) |->
    frame_start_accept || $past(frame_start_accept) || $past(s_axi_bvalid))
    else $error("frame wait left without count or command");
  // both halves are latched first, the register is written one cycle later
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
endmodule : astg_gate_properties
bind astg_gate astg_gate_properties u_prop (.*);

// ---- tb/astg_src.sv ----
// partner: external start line and frame trigger source
`timescale 1ns/100ps
module astg_src (
  input wire logic sys_clk,
  input wire logic line_lvl,
  input wire logic frame_en,
  output logic external_start_edge_signal = 1'h0,
  output logic frame_start_trig = 1'h0
);
  // cable level moves off the clock grid, so the synchroniser is exercised
  always @(line_lvl) external_start_edge_signal <= #37 line_lvl;
  always @(posedge sys_clk) frame_start_trig <= frame_en;
endmodule : astg_src

// ---- tb/astg_gate_bench.sv ----
// bench: register, start trigger and frame gating scenarios
`timescale 1ns/100ps
module astg_gate_bench;
  import astg_pkg::*;
  logic sys_clk = 1'h0, rstn = 1'h0, line_lvl = 1'h0, frame_en = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h13e7;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic external_start_edge_signal, frame_start_trig, frame_start_accept, acq_start_pulse, waiting_frame_start;
  int n_errors = 0, total_checks = 0, n_acc = 0, n_st = 0, cyc = 0, n, s0;
  astg_gate dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .external_start_edge_signal(external_start_edge_signal),
    .frame_start_trig(frame_start_trig),
    .frame_start_accept(frame_start_accept),
    .acq_start_pulse(acq_start_pulse),
    .waiting_frame_start(waiting_frame_start)
  );
  astg_src u_src (
    .sys_clk(sys_clk),
    .line_lvl(line_lvl),
    .frame_en(frame_en),
    .external_start_edge_signal(external_start_edge_signal),
    .frame_start_trig(frame_start_trig)
  );
  initial forever #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da = 1'h0, dw = 1'h0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge sys_clk);
      da |= s_axi_awready;
      dw |= s_axi_wready;
      @(posedge sys_clk);
      if (da) s_axi_awvalid <= 1'h0;
      if (dw) s_axi_wvalid <= 1'h0;
    end while (!(da && dw));
    do @(negedge sys_clk); while (s_axi_bvalid !== 1'h1);
    // only the four aligned words up to the status word are mapped
    chk({30'h0, s_axi_bresp}, {30'h0, ((a & 8'hfc) > ASTG_STAT_OFS) ? ASTG_RESP_SLVERR : ASTG_RESP_OKAY});
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge sys_clk); while (s_axi_arready !== 1'h1);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge sys_clk); while (s_axi_rvalid !== 1'h1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    @(posedge sys_clk);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  // frame trigger held high k cycles; accepts stop at the frame count only while the mode bit is set
  task automatic frames(input int k, input int e);
    int a0;
    a0 = n_acc;
    @(posedge sys_clk);
    frame_en <= 1'h1;
    repeat (k) @(posedge sys_clk);
    frame_en <= 1'h0;
    settle(3);
    chk(n_acc - a0, e);
  endtask : frames
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (frame_start_accept === 1'h1) n_acc <= n_acc + 1;
    if (acq_start_pulse === 1'h1) n_st <= n_st + 1;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    rd(ASTG_CTRL_OFS, 32'h0, ASTG_RESP_OKAY);
    rd(ASTG_FCNT_OFS, 32'h1, ASTG_RESP_OKAY);
    rd(8'h10, 32'h0, ASTG_RESP_SLVERR);
    wr(8'h10, 32'h1f);
    rd(ASTG_CTRL_OFS, 32'h0, ASTG_RESP_OKAY);
    wr(ASTG_FCNT_OFS, 32'h0);
    rd(ASTG_FCNT_OFS, 32'h1, ASTG_RESP_OKAY);
    wr(ASTG_FCNT_OFS, 32'hff);
    rd(ASTG_FCNT_OFS, 32'hff, ASTG_RESP_OKAY);
    wr(ASTG_CTRL_OFS, 32'h19);
    wr(ASTG_CMD_OFS, 32'h2);
    frames(3, 0);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      n = seed[1:0] + 1;
      wr(ASTG_FCNT_OFS, n);
      wr(ASTG_CMD_OFS, 32'h1);
      settle(2);
      chk(waiting_frame_start, 1'h1);
      rd(ASTG_STAT_OFS, 32'h3, ASTG_RESP_OKAY);
      frames(n + 3, n);
      chk(waiting_frame_start, 1'h0);
    end
    wr(ASTG_CTRL_OFS, 32'h11);
    wr(ASTG_CMD_OFS, 32'h1);
    settle(3);
    chk(waiting_frame_start, 1'h0);
    wr(ASTG_FCNT_OFS, 32'h1);
    for (int p = 0; p < 2; p++) begin
      line_lvl <= !p[0];
      wr(ASTG_CTRL_OFS, 32'h13 + 4 * p);
      s0 = n_st;
      line_lvl <= p[0];
      settle(8);
      chk(n_st - s0, 0);
      line_lvl <= !p[0];
      settle(8);
      chk(n_st - s0, 1);
      frames(2, 1);
    end
    wr(ASTG_CMD_OFS, 32'h4);
    wr(ASTG_CTRL_OFS, 32'h10);
    s0 = n_st;
    wr(ASTG_CMD_OFS, 32'h2);
    settle(3);
    chk(n_st - s0, 1);
    frames(8, 8);
    wr(ASTG_CMD_OFS, 32'h4);
    settle(2);
    chk(waiting_frame_start, 1'h0);
    print_verdict();
  end
endmodule : astg_gate_bench
